// File: verilog/adp_pkg.sv
// adp_pkg: constants and carrier types for the channel processing block.
// assumes eight channels of 12-bit converted samples arriving together.
package adp_pkg;
    localparam int CH_N = 8;
    localparam int DW = 12;
    localparam int COEF_N = 12;
    localparam int WIN_N = 24;
    localparam int FIR_SHIFT = 11;
    localparam int GAIN_FRAC = 10;
    localparam int FIFO_DEPTH = 8;
    localparam int SE_DET_CYC = 16;
    // register byte offsets
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_GAIN = 8'h04;
    localparam logic [7:0] A_STAT = 8'h08;
    localparam logic [7:0] A_XREF = 8'h0C;
    localparam logic [7:0] A_COEF_LO = 8'h40;
    localparam logic [7:0] A_COEF_HI = 8'h6C;
    // field positions
    localparam int F_FILT = 0;
    localparam int F_ODD = 1;
    localparam int F_DEC = 2;
    localparam int F_UNLOCK = 4;
    localparam int F_NS = 8;
    localparam int F_XSEL = 15;
    // values after reset, gain limit, decimation and response codes
    localparam logic [31:0] GAIN_RST = 32'h0;
    localparam logic [3:0] GAIN_MAX = 4'hC;
    localparam logic [1:0] DEC_2 = 2'h0;
    localparam logic [1:0] DEC_4 = 2'h1;
    localparam logic [1:0] DEC_8 = 2'h2;
    localparam logic [1:0] DEC_1 = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // gain factors, 10 fractional bits, index = dB
    localparam logic [12:0][12:0] GAIN_Q10 = {13'hFED, 13'hE31, 13'hCA6, 13'hB46,
        13'hA0C, 13'h8F4, 13'h7FB, 13'h71D, 13'h657, 13'h5A6, 13'h509, 13'h47D, 13'h400};
    // low-pass half-band set, h11 first
    localparam logic [11:0][11:0] COEF_RST = {12'h400, 12'h27C, 12'hFFC, 12'hF4E,
        12'h003, 12'h049, 12'hFFE, 12'hFE5, 12'h001, 12'h005, 12'h000, 12'h003};
    typedef struct packed {
        logic [CH_N-1:0][DW-1:0] ch;
    } adp_frame_t;
    typedef struct packed {
        logic [CH_N-1:0] ns_en;
        logic unlock;
        logic [1:0] dec_sel;
        logic odd_tap;
        logic filt_en;
    } adp_cfg_t;
    localparam adp_cfg_t CFG_RST = '0;
endpackage : adp_pkg

// File: verilog/adp_fifo.sv
// adp_fifo: small first-word-fall-through buffer with a registered output.
// assumes one clock; ce low freezes every flop.
`timescale 1ns/1ps
`default_nettype none
module adp_fifo #(
    parameter int W = 96,
    parameter int D = 8
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    localparam int CW = $clog2(D + 1);
    logic [W-1:0] mem_r [D];
    logic [AW-1:0] wp_r, rp_r;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic push, load;
    // ready is registered, so it is computed from the next count
    assign push = ce & in_valid & in_ready;
    assign load = ce & (cnt_r != '0) & (~out_valid | out_ready);
    assign cnt_nxt = cnt_r + CW'(push) - CW'(load);
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (!rstn) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            in_ready <= 1'b0;
            out_valid <= 1'b0;
            out_data <= '0;
        end else if (ce) begin
            cnt_r <= cnt_nxt;
            in_ready <= cnt_nxt != CW'(D);
            if (push) begin
                mem_r[wp_r] <= in_data;
                wp_r <= (wp_r == AW'(D - 1)) ? '0 : wp_r + 1'b1;
            end
            if (load) begin
                out_data <= mem_r[rp_r];
                out_valid <= 1'b1;
                rp_r <= (rp_r == AW'(D - 1)) ? '0 : rp_r + 1'b1;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
        end
    end
endmodule : adp_fifo
`default_nettype wire

// File: verilog/adp_coef_mem.sv
// adp_coef_mem: bank of twelve signed filter coefficients.
// assumes the writer gives an index below twelve; read data are the flops.
`timescale 1ns/1ps
`default_nettype none
module adp_coef_mem (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic we,
    input wire logic [3:0] waddr,
    input wire logic [adp_pkg::DW-1:0] wdata,
    output logic [adp_pkg::COEF_N-1:0][adp_pkg::DW-1:0] coef_q
);
    import adp_pkg::*;
    // one flop word per coefficient, preset to the built-in low-pass set
    for (genvar k = 0; k < COEF_N; k++) begin : g_word
        always_ff @(posedge clk) begin
            if (!rstn) begin
                coef_q[k] <= COEF_RST[k];
            end else if (ce && we && waddr == 4'(k)) begin
                coef_q[k] <= wdata;
            end
        end
    end
endmodule : adp_coef_mem
`default_nettype wire

// File: verilog/adp_top.sv
// adp_top: per-channel gain, noise shift and symmetric FIR with decimation.
// assumes samples of all channels come in together, synchronous to aclk.
`timescale 1ns/1ps
`default_nettype none
module adp_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic aclk_en,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic clock_negative_input,
    input wire logic sample_in_valid,
    output logic sample_in_ready,
    input wire adp_pkg::adp_frame_t sample_in,
    output logic sample_out_valid,
    input wire logic sample_out_ready,
    output adp_pkg::adp_frame_t sample_out,
    output logic clock_bias_enable,
    output logic reference_amp_enable
);
    import adp_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [DW-1:0] sat12(input logic signed [39:0] v);
        if (v > 40'sh7FF) begin
            sat12 = 12'h7FF;
        end else if (v < -40'sh800) begin
            sat12 = 12'h800;
        end else begin
            sat12 = v[DW-1:0];
        end
    endfunction : sat12

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        merge = old;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                merge[b*8 +: 8] = d[b*8 +: 8];
            end
        end
    endfunction : merge

    ////////////////////////////////////////////////////////////////////////
    // register state
    adp_cfg_t cfg_r;
    logic [31:0] gain_r;
    logic xsel_r;
    logic [COEF_N-1:0][DW-1:0] coef_q;
    logic aw_take, w_take, wr_fire, ar_take;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic we_ctrl, we_gain, we_xref, we_coef, wr_err;
    logic [31:0] rd_val, ctrl_word, ctrl_new, gain_new, xref_new;
    logic rd_err;
    logic coef_wa, coef_ra;

    assign aw_take = aclk_en & s_axi_awvalid & s_axi_awready;
    assign w_take = aclk_en & s_axi_wvalid & s_axi_wready;
    assign ar_take = aclk_en & s_axi_arvalid & s_axi_arready;
    // both halves held and no answer pending: perform the write
    assign wr_fire = aclk_en & ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
    assign ctrl_word = {16'h0, cfg_r.ns_en, 3'h0, cfg_r.unlock, cfg_r.dec_sel,
                        cfg_r.odd_tap, cfg_r.filt_en};
    assign ctrl_new = merge(ctrl_word, wdata_r, wstrb_r);
    assign gain_new = merge(gain_r, wdata_r, wstrb_r);
    assign xref_new = merge(32'(xsel_r) << F_XSEL, wdata_r, wstrb_r);
    assign coef_wa = awaddr_r >= A_COEF_LO && awaddr_r <= A_COEF_HI && awaddr_r[1:0] == 2'h0;
    assign coef_ra = s_axi_araddr >= A_COEF_LO && s_axi_araddr <= A_COEF_HI
                     && s_axi_araddr[1:0] == 2'h0;

    // write address decode
    always_comb begin
        we_ctrl = 1'b0;
        we_gain = 1'b0;
        we_xref = 1'b0;
        we_coef = 1'b0;
        wr_err = 1'b0;
        if (awaddr_r == A_CTRL) begin
            we_ctrl = wr_fire;
        end else if (awaddr_r == A_GAIN) begin
            we_gain = wr_fire;
        end else if (awaddr_r == A_STAT) begin
            we_ctrl = 1'b0;                                  // read-only, write dropped
        end else if (awaddr_r == A_XREF) begin
            we_xref = wr_fire & cfg_r.unlock;
            wr_err = ~cfg_r.unlock;
        end else if (coef_wa) begin
            we_coef = wr_fire;
        end else begin
            wr_err = 1'b1;
        end
    end

    // read address decode
    always_comb begin
        rd_val = 32'h0;
        rd_err = 1'b0;
        if (s_axi_araddr == A_CTRL) begin
            rd_val = ctrl_word;
        end else if (s_axi_araddr == A_GAIN) begin
            rd_val = gain_r;
        end else if (s_axi_araddr == A_STAT) begin
            rd_val = {28'h0, sample_out_valid, sample_in_ready, ~reference_amp_enable,
                      ~clock_bias_enable};
        end else if (s_axi_araddr == A_XREF) begin
            rd_val = cfg_r.unlock ? (32'(xsel_r) << F_XSEL) : 32'h0;
            rd_err = ~cfg_r.unlock;
        end else if (coef_ra) begin
            rd_val = {20'h0, coef_q[s_axi_araddr[5:2]]};
        end else begin
            rd_err = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus handshakes: ready drops once a half is held, rises after B
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0;
            wstrb_r <= 4'h0;
        end else if (aclk_en) begin
            if (aw_take) begin
                awaddr_r <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (w_take) begin
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // read channel answers on the same edge that takes the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else if (aclk_en) begin
            if (ar_take) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_val;
                s_axi_rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // control fields; one decimation field serves all channels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_r <= CFG_RST;
            gain_r <= GAIN_RST;
            xsel_r <= 1'b0;
        end else if (aclk_en) begin
            if (we_ctrl) begin
                cfg_r.filt_en <= ctrl_new[F_FILT];
                cfg_r.odd_tap <= ctrl_new[F_ODD];
                cfg_r.dec_sel <= ctrl_new[F_DEC +: 2];
                cfg_r.unlock <= ctrl_new[F_UNLOCK];
                cfg_r.ns_en <= ctrl_new[F_NS +: CH_N];
            end
            if (we_gain) begin
                gain_r <= gain_new;
            end
            if (we_xref) begin
                xsel_r <= xref_new[F_XSEL];
            end
        end
    end

    adp_coef_mem u_coef (
        .clk(aclk),
        .rstn(aresetn),
        .ce(aclk_en),
        .we(we_coef),
        .waddr(awaddr_r[5:2]),
        .wdata(wdata_r[DW-1:0]),
        .coef_q(coef_q)
    );

    ////////////////////////////////////////////////////////////////////////
    // reference and clock-input supervision
    logic cn_r;
    logic [4:0] se_cnt_r;

    // a low negative clock pin that stays low means a single-ended source
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cn_r <= 1'b0;
            se_cnt_r <= 5'h00;
            clock_bias_enable <= 1'b1;
            reference_amp_enable <= 1'b1;
        end else if (aclk_en) begin
            cn_r <= clock_negative_input;
            reference_amp_enable <= ~(cfg_r.unlock & xsel_r);
            if (cn_r) begin
                se_cnt_r <= 5'h00;
                clock_bias_enable <= 1'b1;
            end else if (se_cnt_r == 5'(SE_DET_CYC - 1)) begin
                clock_bias_enable <= 1'b0;
            end else begin
                se_cnt_r <= se_cnt_r + 5'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sample path: gain, noise shift, filter, decimate, buffer
    logic accept, push, phase_r, v1_r, v2_r, emit;
    logic [2:0] dec_cnt_r, dec_last;
    adp_frame_t raw_frame, fir_frame, buf_in;

    // whole frame steps on one handshake, so channels stay aligned
    assign accept = aclk_en & sample_in_valid & sample_in_ready;
    assign dec_last = (cfg_r.dec_sel == DEC_2) ? 3'h1 :
                      (cfg_r.dec_sel == DEC_4) ? 3'h3 :
                      (cfg_r.dec_sel == DEC_8) ? 3'h7 : 3'h0;
    assign emit = ~cfg_r.filt_en | (dec_cnt_r >= dec_last);
    assign push = accept & v2_r & emit;
    assign buf_in = cfg_r.filt_en ? fir_frame : raw_frame;

    // alternating sign and decimation phase advance per taken frame
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_r <= 1'b0;
            v1_r <= 1'b0;
            v2_r <= 1'b0;
            dec_cnt_r <= 3'h0;
        end else if (accept) begin
            phase_r <= ~phase_r;
            v1_r <= 1'b1;
            v2_r <= v1_r;
            if (v2_r) begin
                dec_cnt_r <= emit ? 3'h0 : dec_cnt_r + 3'h1;
            end
        end
    end

    for (genvar c = 0; c < CH_N; c++) begin : g_ch
        logic [3:0] gc;
        logic [12:0] gq;
        logic signed [39:0] gprod;
        logic [DW-1:0] g_r, ns_r;
        logic [WIN_N-2:0][DW-1:0] tap_r;
        logic signed [DW-1:0] w [WIN_N];
        logic signed [39:0] acc;
        logic signed [12:0] pair;
        logic signed [DW-1:0] mate;

        assign gc = gain_r[c*4 +: 4];
        // codes above twelve are unsupported and run at unity
        assign gq = (gc > GAIN_MAX) ? GAIN_Q10[0] : GAIN_Q10[gc];
        assign gprod = 40'($signed(sample_in.ch[c])) * 40'($signed({1'b0, gq}));
        assign raw_frame.ch[c] = ns_r;

        // window: newest is the shifted sample, then the delay line
        assign w[0] = ns_r;
        for (genvar j = 1; j < WIN_N; j++) begin : g_win
            assign w[j] = tap_r[j-1];
        end

        // symmetric sum: pairs mirrored, odd form keeps h11 alone
        always_comb begin
            acc = 40'sh0;
            pair = 13'sh0;
            mate = 12'sh0;
            for (int k = 0; k < COEF_N; k++) begin
                if (!cfg_r.odd_tap) begin
                    mate = w[WIN_N-1-k];
                end else if (k == COEF_N - 1) begin
                    mate = 12'sh0;
                end else begin
                    mate = w[WIN_N-2-k];
                end
                pair = 13'(w[k]) + 13'(mate);
                acc = acc + 40'(pair) * 40'($signed(coef_q[k]));
            end
        end
        assign fir_frame.ch[c] = sat12(acc >>> FIR_SHIFT);

        // gain result saturates instead of wrapping at full scale
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                g_r <= '0;
                ns_r <= '0;
                tap_r <= '0;
            end else if (accept) begin
                g_r <= sat12(gprod >>> GAIN_FRAC);
                ns_r <= (cfg_r.ns_en[c] && phase_r) ?
                        sat12(-40'($signed(g_r))) : g_r;
                tap_r <= {tap_r[WIN_N-3:0], ns_r};
            end
        end
    end

    adp_fifo #(
        .W(CH_N * DW),
        .D(FIFO_DEPTH)
    ) u_fifo (
        .clk(aclk),
        .rstn(aresetn),
        .ce(aclk_en),
        .in_valid(push),
        .in_ready(sample_in_ready),
        .in_data(buf_in),
        .out_valid(sample_out_valid),
        .out_ready(sample_out_ready),
        .out_data(sample_out)
    );
endmodule : adp_top
`default_nettype wire

// File: verif/adp_props.sv
// adp_props: bus and stream timing checks on adp_top ports.
// assumes the single aclk domain; bound into every adp_top.
`timescale 1ns/1ps
`default_nettype none
module adp_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic aclk_en,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic clock_negative_input,
    input wire logic sample_out_valid,
    input wire logic sample_out_ready,
    input wire adp_pkg::adp_frame_t sample_out,
    input wire logic clock_bias_enable
);
    import adp_pkg::*;
    logic [4:0] low_r, low_nxt;
    // low-pin run, saturates
    assign low_nxt = clock_negative_input ? 5'h0 : (low_r == 5'h1F ? low_r : low_r + 5'h1);
    always_ff @(posedge aclk) begin
        if (!aresetn)
            low_r <= 5'h0;
        else if (aclk_en)
            low_r <= low_nxt;
    end
    ////////////////////////////////////////////////////////////////
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_b_follow: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready && aclk_en |-> ##2 s_axi_bvalid) else $error("no write answer");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    a_w_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while busy");
    a_r_follow: assert property (s_axi_arvalid && s_axi_arready && aclk_en |=> s_axi_rvalid)
        else $error("no read answer");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
    a_r_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    a_out_hold: assert property (sample_out_valid && !sample_out_ready |=>
        sample_out_valid && $stable(sample_out)) else $error("output sample dropped");
    a_bias_off: assert property (low_r >= 5'h12 |-> !clock_bias_enable)
        else $error("single-ended clock missed");
    a_bias_on: assert property (clock_negative_input && aclk_en |-> ##[1:2] clock_bias_enable)
        else $error("bias not restored");
    cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_SLVERR);
    cover property (sample_out_valid && sample_out_ready);
    cover property ($fell(clock_bias_enable));
endmodule : adp_props
bind adp_top adp_props chk_u (.*);
`default_nettype wire

// File: verif/adp_sink.sv
// adp_sink: output stage taking processed frames off adp_top.
// assumes mode is changed just after a rising aclk edge.
`timescale 1ns/1ps
`default_nettype none
module adp_sink (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [1:0] mode,
    input wire logic sample_out_valid,
    input wire adp_pkg::adp_frame_t sample_out,
    output logic sample_out_ready
);
    import adp_pkg::*;
    adp_frame_t got[$];
    logic tog_r;
    // mode 0 prompt, 1 alternate, 2 stalled
    assign sample_out_ready = (mode == 2'h0) || (mode == 2'h1 && tog_r);
    always @(posedge aclk) begin
        tog_r <= aresetn ? !tog_r : 1'b0;
        if (aresetn && sample_out_valid && sample_out_ready)
            got.push_back(sample_out);
    end
endmodule : adp_sink
`default_nettype wire

// File: verif/tb.sv
// tb: scenario bench for adp_top with an output-stage sink.
// assumes one 25 MHz clock and registers over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import adp_pkg::*;
    logic aclk, aresetn, aclk_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, mode;
    logic clock_negative_input, sample_in_valid, sample_in_ready, sample_out_valid;
    logic sample_out_ready, clock_bias_enable, reference_amp_enable;
    adp_frame_t sample_in, sample_out;
    int num_errors = 0, n_checks = 0, cyc = 0;
    adp_top dut_u (.*);
    adp_sink sink_u (.*);
    ////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    task automatic chk(input string nm, input logic [95:0] exp, input logic [95:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    function automatic logic [11:0] sat(input int v);
        if (v > 2047)
            return 12'h7FF;
        if (v < -2048)
            return 12'h800;
        return v[11:0];
    endfunction : sat
    // master keeps each channel up until its own ready edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk("bresp", er, s_axi_bresp);
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk("rdata", ed, s_axi_rdata);
        chk("rresp", er, s_axi_rresp);
        @(posedge aclk);
    endtask : rd
    task automatic send(input adp_frame_t f, input int n);
        sample_in <= f;
        sample_in_valid <= 1'b1;
        while (n > 0) begin
            @(posedge aclk);
            if (sample_in_ready)
                n--;
        end
        sample_in_valid <= 1'b0;
        @(posedge aclk);
    endtask : send
    task automatic wait_out;
        for (int i = 0; i < 100 && (i < 3 || sample_out_valid); i++)
            @(posedge aclk);
    endtask : wait_out
    ////////////////////////////////////////////////////////////////
    task automatic t_reset;
        chk("bias", 1, clock_bias_enable);
        chk("amp", 1, reference_amp_enable);
        rd(A_GAIN, 32'h0, RESP_OKAY);
        rd(A_COEF_LO + 8'h20, 32'hF4E, RESP_OKAY);
        rd(8'h20, 32'h0, RESP_SLVERR);
    endtask : t_reset
    task automatic t_gain;
        adp_frame_t f, e;
        int x, k;
        wr(A_CTRL, 32'h0, RESP_OKAY);
        for (int g = 0; g < 2; g++) begin
            wr(A_GAIN, g ? 32'hCBA98765 : 32'h76543210, RESP_OKAY);
            for (int c = 0; c < CH_N; c++) begin
                x = c % 2 ? -700 : 700;
                k = g ? c + 5 : c;
                f.ch[c] = x[11:0];
                e.ch[c] = sat((x * int'(GAIN_Q10[k])) >>> 10);
            end
            send(f, 4);
            wait_out();
            chk("gain", e, sink_u.got[$]);
        end
    endtask : t_gain
    task automatic t_filter;
        adp_frame_t f, e;
        int so, se, n0, n, nd;
        so = 0;
        for (int k = 0; k < COEF_N; k++)
            so = so + int'($signed(COEF_RST[k])) * (k < 11 ? 2 : 1);
        se = so + int'($signed(COEF_RST[11]));
        wr(A_GAIN, 32'h0, RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            n0 = sink_u.got.size();
            nd = i == 3 ? 1 : 2 << i;
            wr(A_CTRL, 32'h1 | (i == 0 ? 32'h2 : 32'h0) | (i << 2), RESP_OKAY);
            for (int c = 0; c < CH_N; c++) begin
                f.ch[c] = 12'h190;
                e.ch[c] = sat((400 * (i == 0 ? so : se)) >>> 11);
            end
            send(f, 34);
            wait_out();
            n = sink_u.got.size() - n0;
            chk("dec_count", 1, n >= 34 / nd - 1 && n <= 34 / nd + 1);
            chk("fir", e, sink_u.got[$]);
        end
    endtask : t_filter
    task automatic t_shift;
        logic [11:0] a, b;
        wr(A_CTRL, 32'h100, RESP_OKAY);
        send({CH_N{12'h12C}}, 6);
        wait_out();
        a = sink_u.got[$].ch[0];
        b = sink_u.got[$-1].ch[0];
        chk("ns_pair", 12'h0, 12'(a + b));
        chk("ns_mag", 1, a == 12'h12C || a == 12'hED4);
        chk("ns_off", 12'h12C, sink_u.got[$].ch[1]);
    endtask : t_shift
    task automatic t_ref;
        wr(A_CTRL, 32'h0, RESP_OKAY);
        wr(A_XREF, 32'h8000, RESP_SLVERR);
        rd(A_XREF, 32'h0, RESP_SLVERR);
        chk("amp", 1, reference_amp_enable);
        wr(A_CTRL, 32'h10, RESP_OKAY);
        wr(A_XREF, 32'h8000, RESP_OKAY);
        rd(A_XREF, 32'h8000, RESP_OKAY);
        chk("amp", 0, reference_amp_enable);
        wr(A_CTRL, 32'h0, RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk("amp", 1, reference_amp_enable);
    endtask : t_ref
    task automatic t_fifo;
        int n0, n;
        n0 = sink_u.got.size();
        n = 0;
        mode <= 2'h2;
        sample_in <= {CH_N{12'h055}};
        sample_in_valid <= 1'b1;
        repeat (40) begin
            @(posedge aclk);
            if (sample_in_ready)
                n++;
        end
        sample_in_valid <= 1'b0;
        mode <= 2'h1;
        chk("fill", FIFO_DEPTH + 1, n);
        wait_out();
        chk("drain", n, sink_u.got.size() - n0);
        mode <= 2'h0;
    endtask : t_fifo
    task automatic t_se;
        clock_negative_input <= 1'b0;
        aclk_en <= 1'b0;
        repeat (20) @(posedge aclk);
        chk("bias_frz", 1, clock_bias_enable);
        aclk_en <= 1'b1;
        repeat (20) @(posedge aclk);
        chk("bias", 0, clock_bias_enable);
        clock_negative_input <= 1'b1;
        repeat (3) @(posedge aclk);
        chk("bias", 1, clock_bias_enable);
    endtask : t_se
    ////////////////////////////////////////////////////////////////
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    // ceiling far above all scenarios
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            close_out();
        end
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, sample_in_valid, mode} = '0;
        sample_in = '0;
        aclk_en = 1'b1;
        s_axi_wstrb = 4'hF;
        clock_negative_input = 1'b1;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_gain();
        t_filter();
        t_shift();
        t_ref();
        t_fifo();
        t_se();
        close_out();
    end
endmodule : tb
`default_nettype wire
